// *** mcd_checker.sv ***
// Port assertions for the completion detector
`timescale 1ns/1ps
module mcd_checker #(
  parameter PW = 32
)(
  input wire clock,
  input wire srst,
  input wire [PW-1:0] settleWindow,
  input wire driverDoneSourceSel,
  input wire pulseBusy,
  input wire [PW-1:0] positionCommand,
  input wire [PW-1:0] feedbackPosition,
  input wire driverDoneIn,
  input wire doneQueryCmd,
  input wire motionDonePin,
  input wire doneStatus,
  input wire queryValid,
  input wire queryDone,
  input wire seqStall,
  input wire seqRelease,
  input wire [PW-1:0] positionError,
  input wire alarm,
  input wire [7:0] alarmCode
);
  // ****************************************
  // Properties, one clock domain
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_query_echo: assert property (doneQueryCmd |=>
    queryValid && queryDone == $past(doneStatus)) else $error("query");
  a_pin_follows: assert property (motionDonePin == doneStatus)
    else $error("pin");
  a_busy_clears: assert property (pulseBusy |=> !doneStatus)
    else $error("busy");
  a_plain_done: assert property (!driverDoneSourceSel &&
    settleWindow == 0 && !pulseBusy |=> doneStatus) else $error("plain");
  a_driver_source: assert property (driverDoneSourceSel &&
    !pulseBusy |=> doneStatus == $past(driverDoneIn)) else $error("drv");
  a_error_calc: assert property (!srst |=> positionError ==
    $past(positionCommand) - $past(feedbackPosition)) else $error("err");
  a_release_pulse: assert property (seqRelease |->
    $past(seqStall) ##1 !seqRelease) else $error("release");
  a_alarm_code: assert property ($rose(alarm) |-> alarmCode ==
    ($past(driverDoneSourceSel) ? 8'h6f : 8'h10)) else $error("code");
  a_alarm_stall: assert property (alarm |-> seqStall &&
    !seqRelease) else $error("stall");
endmodule // mcd_checker
bind mcd_motion_done mcd_checker #(.PW(PW)) u_mcd_checker (.*);

// *** mcd_driver_model.sv ***
// Motor driver model giving its done level after pulses stop
`timescale 1ns/1ps
module mcd_driver_model #(
  parameter LAG = 4
)(
  input wire clock,
  input wire pulseBusy,
  input wire stuck,
  output reg driverDoneIn
);
  reg [7:0] lagCnt;
  // Settles once and stays steady, so no chatter at slow speed
  always @(posedge clock)
  begin
    lagCnt <= pulseBusy ? 8'h00 : lagCnt + {7'h00, lagCnt != LAG};
    driverDoneIn <= !pulseBusy && !stuck && lagCnt == LAG;
  end
endmodule // mcd_driver_model

// *** mcd_map.vh ***
// Constants for the motion completion detector
// Behaviour
// - Completion source chosen by settle window value together with driver source select.
// - After reset window and select are zero, completion means pulses finished.
// - Select 0, window nonzero: pulses ended and error magnitude within window.
// - Select 1: completion follows driver done input, window ignored.
// - Selected completion status drives the completion output pin.
// - Completion status readable any time via bus and serial query.
// - Wait instruction stalls sequencer until completion, then releases it.
// - Home seeking checks completion at every intermediate stop before next stage.
// - Wait or home stop: pulses ended, no completion in wait time raises alarm.
// - Alarm code 10h for window source, 6Fh for driver source.
// - Completion timeout programmable, default six seconds.
// - Position error equals position command minus feedback position.
`ifndef MCD_MAP_VH
`define MCD_MAP_VH
// ****************************************************
// Reset values and codes
// ****************************************************
`define MCD_WINDOW_RESET 32'h0000_0000
`define MCD_SRC_SEL_RESET 1'b0
`define MCD_ALARM_WINDOW 8'h10
`define MCD_ALARM_DRIVER 8'h6f
`define MCD_ALARM_NONE 8'h00
// ****************************************************
// Timing
// ****************************************************
`define MCD_CLK_HZ 100000000
`define MCD_TIMEOUT_MS 6000
`define MCD_MS_CYCLES (`MCD_CLK_HZ / 1000)
`define MCD_TICK_DIV 16'd9999
`endif

// *** mcd_motion_done.v ***
// Motion completion detector: source select, status, waits and alarm
`timescale 1ns/1ps
`include "mcd_map.vh"
module mcd_motion_done #(
  parameter PW = 32,
  parameter TW = 16,
  parameter MS_CYCLES = `MCD_MS_CYCLES
)(
  input wire clock,
  input wire srst,
  input wire [PW-1:0] settleWindow,
  input wire driverDoneSourceSel,
  input wire pulseBusy,
  input wire [PW-1:0] positionCommand,
  input wire [PW-1:0] feedbackPosition,
  input wire driverDoneIn,
  input wire waitDoneCmd,
  input wire homeSeekPositive,
  input wire homeSeekNegative,
  input wire homeStop,
  input wire [TW-1:0] completionTimeout,
  input wire doneQueryCmd,
  input wire alarmClear,
  output reg motionDonePin,
  output reg doneStatus,
  output reg queryValid,
  output reg queryDone,
  output wire seqStall,
  output reg seqRelease,
  output reg homeAdvance,
  output reg [PW-1:0] positionError,
  output reg alarm,
  output reg [7:0] alarmCode
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_HOME = 2'd2;
  localparam ST_ALARM = 2'd3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg pulseBusyDly_reg;
  reg [PW-1:0] errMag;
  reg withinWindow;
  reg sourceDone;
  wire pulseEnd;
  wire pulseStart;
  wire waiting;
  wire expired;
  wire homing;

  // ****************************************************
  // Position error and window check
  // ****************************************************
  // Registered so the error is one clean word each cycle
  always @(posedge clock)
  begin
    if (srst)
      positionError <= `MCD_WINDOW_RESET;
    else
      positionError <= positionCommand - feedbackPosition;
  end

  // Magnitude in two's complement, wrap at most-negative is tolerated
  always @*
  begin
    errMag = positionError[PW-1] ? (~positionError + 1'b1) : positionError;
    withinWindow = (errMag <= settleWindow);
  end

  // ****************************************************
  // Source selection
  // ****************************************************
  // Zero window with select low reduces to plain end of pulses
  always @*
  begin
    if (driverDoneSourceSel)
      sourceDone = driverDoneIn;
    else if (settleWindow == `MCD_WINDOW_RESET)
      sourceDone = !pulseBusy;
    else
      sourceDone = !pulseBusy && withinWindow;
  end

  // ****************************************************
  // Edge detect on pulse generation
  // ****************************************************
  always @(posedge clock)
  begin
    if (srst)
      pulseBusyDly_reg <= 1'b0;
    else
      pulseBusyDly_reg <= pulseBusy;
  end
  assign pulseEnd = pulseBusyDly_reg && !pulseBusy;
  assign pulseStart = !pulseBusyDly_reg && pulseBusy;

  // ****************************************************
  // Completion status and pin
  // ****************************************************
  // A new motion clears status at once, before the source catches up
  always @(posedge clock)
  begin
    if (srst)
    begin
      doneStatus <= 1'b0;
      motionDonePin <= 1'b0;
    end
    else
    begin
      doneStatus <= pulseStart ? 1'b0 : sourceDone;
      motionDonePin <= pulseStart ? 1'b0 : sourceDone;
    end
  end

  // Serial query answered one cycle later with the live status
  always @(posedge clock)
  begin
    if (srst)
    begin
      queryValid <= 1'b0;
      queryDone <= 1'b0;
    end
    else
    begin
      queryValid <= doneQueryCmd;
      if (doneQueryCmd)
        queryDone <= doneStatus;
    end
  end

  // ****************************************************
  // Wait sequencing
  // ****************************************************
  assign homing = homeSeekPositive || homeSeekNegative;
  assign waiting = (state_reg == ST_WAIT) || (state_reg == ST_HOME);
  assign seqStall = (state_reg == ST_WAIT) || (state_reg == ST_ALARM);

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (waitDoneCmd)
          state_next = ST_WAIT;
        else if (homing && homeStop)
          state_next = ST_HOME;
      end
      ST_WAIT, ST_HOME:
      begin
        if (doneStatus && !pulseBusy)
          state_next = ST_IDLE;
        else if (expired)
          state_next = ST_ALARM;
      end
      ST_ALARM:
      begin
        if (alarmClear)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Release strobes fire on the exit from a wait that completed
  always @(posedge clock)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
      seqRelease <= 1'b0;
      homeAdvance <= 1'b0;
      alarm <= 1'b0;
      alarmCode <= `MCD_ALARM_NONE;
    end
    else
    begin
      state_reg <= state_next;
      seqRelease <= (state_reg == ST_WAIT) && (state_next == ST_IDLE);
      homeAdvance <= (state_reg == ST_HOME) && (state_next == ST_IDLE);
      if (waiting && (state_next == ST_ALARM))
      begin
        alarm <= 1'b1;
        alarmCode <= driverDoneSourceSel ? `MCD_ALARM_DRIVER :
          `MCD_ALARM_WINDOW;
      end
      else if (state_reg == ST_ALARM && alarmClear)
      begin
        alarm <= 1'b0;
        alarmCode <= `MCD_ALARM_NONE;
      end
    end
  end

  // ****************************************************
  // Timeout counter
  // ****************************************************
  // Counts only once pulses are done, restarting at each pulse end
  mcd_wait_timer #(
    .MS_CYCLES(MS_CYCLES),
    .TW(TW)
  ) waitTimer (
    .clock(clock),
    .srst(srst),
    .restart(pulseEnd),
    .run(waiting && !pulseBusy),
    .limitMs(completionTimeout),
    .expired(expired)
  );
endmodule // mcd_motion_done

// *** mcd_motion_done_bench.sv ***
// Directed bench for the completion detector
`timescale 1ns/1ps
module mcd_motion_done_bench;
  reg clock, srst, sel, busy, qry, wcmd, hsp, hsn, hstop, clr, stuck;
  reg [31:0] win, cmd, fb;
  wire pin, done, qv, qd, stall, rel, adv, alarm, drvDone;
  wire [31:0] err;
  wire [7:0] code;
  integer miscompares, total_checks, i, j;
  // Short millisecond so timeouts take tens of cycles
  mcd_motion_done #(.MS_CYCLES(10)) u_mcd_motion_done (.clock(clock),
    .srst(srst), .settleWindow(win), .driverDoneSourceSel(sel),
    .pulseBusy(busy), .positionCommand(cmd), .feedbackPosition(fb),
    .driverDoneIn(drvDone), .waitDoneCmd(wcmd), .homeSeekPositive(hsp),
    .homeSeekNegative(hsn), .homeStop(hstop),
    .completionTimeout(16'h0003), .doneQueryCmd(qry), .alarmClear(clr),
    .motionDonePin(pin), .doneStatus(done), .queryValid(qv),
    .queryDone(qd), .seqStall(stall), .seqRelease(rel),
    .homeAdvance(adv), .positionError(err), .alarm(alarm),
    .alarmCode(code));
  mcd_driver_model u_mcd_driver_model (.clock(clock), .pulseBusy(busy),
    .stuck(stuck), .driverDoneIn(drvDone));
  task finish_test;
  begin
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("BAD %0s exp %h seen %h", name, exp, seen);
    end
  end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // Bounded wait: 0 release, 1 alarm, 2 home advance
  task waitFor(input integer w);
  begin
    i = 0;
    while (i < 200 && (w == 0 ? rel : w == 1 ? alarm : adv) !== 1'b1)
    begin
      @(posedge clock);
      i = i + 1;
    end
    if (i == 200)
    begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  endtask
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    miscompares = 0; total_checks = 0;
    srst = 1; busy = 1; sel = 0; win = 0; cmd = 0; fb = 0;
    qry = 0; wcmd = 0; hsp = 0; hsn = 0; hstop = 0; clr = 0; stuck = 0;
    tick(4);
    srst <= 0;
    tick(3); check("busy", done, 0);
    busy <= 0; tick(3); check("plain", done, 1);
    check("pin", pin, 1);
    qry <= 1; tick(1); qry <= 0; tick(1); check("query", {qv, qd}, 3);
    // Wait issued mid-move holds the sequencer until pulses end
    busy <= 1; tick(1); wcmd <= 1; tick(1); wcmd <= 0; busy <= 0;
    tick(1); check("stall", stall, 1);
    waitFor(0); check("free", stall, 0);
    // Window edges both sides, inclusive
    win <= 5; cmd <= 100;
    for (j = 0; j < 4; j = j + 1)
    begin
      fb <= j < 2 ? 94 + j : 108 - j; tick(4);
      check("window", done, j % 2);
      check("error", err, 32'd100 - fb);
    end
    // Let the new error reach the status before the wait is issued
    fb <= 90; stuck <= 1; tick(3);
    wcmd <= 1; tick(1); wcmd <= 0;
    waitFor(1); check("code", code, 8'h10);
    clr <= 1; tick(1); clr <= 0; tick(2); check("clear", alarm, 0);
    // Driver source: window ignored, silent driver times out
    sel <= 1; wcmd <= 1; tick(1); wcmd <= 0;
    waitFor(1); check("code", code, 8'h6f);
    clr <= 1; stuck <= 0; tick(1); clr <= 0; tick(8);
    check("driver", done, 1);
    hsp <= 1; hstop <= 1; tick(1); hstop <= 0;
    waitFor(2); check("home", adv, 1);
    // Opposite direction stops are checked the same way
    hsp <= 0; hsn <= 1; hstop <= 1; tick(1); hstop <= 0;
    waitFor(2); check("homeneg", adv, 1);
    finish_test;
  end
endmodule // mcd_motion_done_bench

// *** mcd_wait_timer.v ***
// Millisecond-based timeout counter for completion waits
`timescale 1ns/1ps
module mcd_wait_timer #(
  parameter MS_CYCLES = 100000,
  parameter TW = 16
)(
  input wire clock,
  input wire srst,
  input wire restart,
  input wire run,
  input wire [TW-1:0] limitMs,
  output reg expired
);
  reg [16:0] divCount_reg;
  reg [TW-1:0] msCount_reg;
  wire msTick;

  // ****************************************************
  // Millisecond enable divider
  // ****************************************************
  assign msTick = run && (divCount_reg == MS_CYCLES - 1);

  // Divider restarts with the wait so timing is whole milliseconds
  always @(posedge clock)
  begin
    if (srst || restart || !run)
      divCount_reg <= 17'h00000;
    else if (msTick)
      divCount_reg <= 17'h00000;
    else
      divCount_reg <= divCount_reg + 17'h00001;
  end

  // ****************************************************
  // Elapsed count and expiry flag
  // ****************************************************
  // Saturates at the limit so expiry stays high
  always @(posedge clock)
  begin
    if (srst || restart || !run)
    begin
      msCount_reg <= {TW{1'b0}};
      expired <= 1'b0;
    end
    else
    begin
      if (msTick && !expired)
        msCount_reg <= msCount_reg + 1'b1;
      if (msCount_reg >= limitMs)
        expired <= 1'b1;
    end
  end
endmodule // mcd_wait_timer
